//--- bench/nvac_ctrl_bench.sv
`timescale 1ns/1ps
module nvac_ctrl_bench;
   // Clock, reset and register bus stimulus
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic sfrBank = 1'h0;
   logic [6:0] sfrAddr = 7'h00;
   logic sfrWr = 1'h0;
   logic [7:0] sfrWdata = 8'h00;
   logic doneClr = 1'h0;
   logic [7:0] sfrRdata;
   logic doneFlag;
   // Scoreboard state
   logic rdReq = 1'h0;
   logic rdSeen = 1'h0;
   logic [8:0] expQ[$];
   logic [7:0] expMem [64];
   logic expDone = 1'h0;
   logic [5:0] base;
   int fail_count = 0;
   int total_checks = 0;

   // One tick of the write timer for sims keeps each write at 20 clocks
   nvac_ctrl #(.WR_TICKS(1)) dut (
      .clk(clk),
      .sys_rst(sys_rst),
      .sfrBank(sfrBank),
      .sfrAddr(sfrAddr),
      .sfrWr(sfrWr),
      .sfrWdata(sfrWdata),
      .sfrRdata(sfrRdata),
      .doneClr(doneClr),
      .doneFlag(doneFlag)
   );

   // 20 MHz clock
   always #25 clk = ~clk;

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (fail_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Bus write; strobe drops a cycle later so no two drives share a step
   task automatic wr(input logic [6:0] a, input logic b, input logic [7:0] d);
      @(negedge clk);
      sfrAddr = a;
      sfrBank = b;
      sfrWdata = d;
      sfrWr = 1'h1;
      @(negedge clk);
      sfrWr = 1'h0;
   endtask

   // Present an address and note the expected {done, data} answer
   task automatic rd(input logic [6:0] a, input logic b, input logic [7:0] d);
      @(negedge clk);
      sfrAddr = a;
      sfrBank = b;
      rdReq = 1'h1;
      expQ.push_back({expDone, d});
      @(negedge clk);
      rdReq = 1'h0;
   endtask

   task automatic storeByte(input logic [5:0] a, input logic [7:0] d);
      wr(nvac_pkg::NVA_OFS, 1'h0, {2'h0, a});
      wr(nvac_pkg::NVD_OFS, 1'h0, d);
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h08);
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h0C);
      expMem[a] = d;
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h0C);
      repeat (25) @(negedge clk);
      expDone = 1'h1;
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h08);
      rd(nvac_pkg::NVD_OFS, 1'h0, d);
      @(negedge clk);
      doneClr = 1'h1;
      @(negedge clk);
      doneClr = 1'h0;
      expDone = 1'h0;
   endtask

   task automatic fetchByte(input logic [5:0] a);
      wr(nvac_pkg::NVA_OFS, 1'h0, {2'h0, a});
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h0A);
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h0B);
      // Store start lands while the read still runs and must be ignored
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h0E);
      repeat (4) @(negedge clk);
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h0A);
      rd(nvac_pkg::NVD_OFS, 1'h0, expMem[a]);
   endtask

   // A read start during a write is ignored and data edits miss the latched store byte; set beats clear
   task automatic busyStore(input logic [5:0] a, input logic [7:0] d);
      wr(nvac_pkg::NVA_OFS, 1'h0, {2'h0, a});
      wr(nvac_pkg::NVD_OFS, 1'h0, d);
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h08);
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h0C);
      expMem[a] = d;
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h0B);
      wr(nvac_pkg::NVD_OFS, 1'h0, ~d);
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h0E);
      // Clear pulse sampled on the very edge at which the write ends
      repeat (nvac_pkg::TICK_CYC - 7) @(negedge clk);
      doneClr = 1'h1;
      @(negedge clk);
      doneClr = 1'h0;
      expDone = 1'h1;
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h0A);
      rd(nvac_pkg::NVD_OFS, 1'h0, ~d);
      @(negedge clk);
      doneClr = 1'h1;
      @(negedge clk);
      doneClr = 1'h0;
      expDone = 1'h0;
   endtask

   // Read data lands one edge after the address; compare oldest note
   always @(posedge clk)
      rdSeen <= rdReq;

   always @(negedge clk)
   begin
      if (rdSeen)
      begin
         if (expQ.size() == 0)
            chk(9'h1FF, 9'h000);
         else
            chk({doneFlag, sfrRdata}, expQ.pop_front());
      end
   end

   // Watchdog well beyond the expected few hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end

   // Main sequence
   initial
   begin
      void'($urandom(11036));
      repeat (8) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'h0;
      rd(nvac_pkg::NVA_OFS, 1'h0, 8'h00);
      rd(nvac_pkg::NVD_OFS, 1'h0, 8'h00);
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h00);
      rd(nvac_pkg::CTL_OFS, 1'h0, 8'h00);
      // Control written from bank 0 must not land
      wr(nvac_pkg::CTL_OFS, 1'h0, 8'h0A);
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h00);
      wr(nvac_pkg::NVA_OFS, 1'h0, 8'hFF);
      rd(nvac_pkg::NVA_OFS, 1'h0, 8'h3F);
      // Starts without their enables must leave control at zero
      wr(nvac_pkg::NVD_OFS, 1'h0, 8'h5A);
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h04);
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h00);
      wr(nvac_pkg::CTL_OFS, 1'h1, 8'h01);
      rd(nvac_pkg::CTL_OFS, 1'h1, 8'h00);
      rd(nvac_pkg::NVD_OFS, 1'h0, 8'h5A);
      storeByte(6'h00, 8'hA5);
      storeByte(6'h3F, 8'h3C);
      base = 6'($urandom());
      for (int i = 1; i < 5; i++)
         storeByte(base ^ 6'(i), 8'($urandom()));
      busyStore(base ^ 6'h5, 8'($urandom()));
      fetchByte(6'h00);
      fetchByte(6'h3F);
      for (int i = 1; i < 6; i++)
         fetchByte(base ^ 6'(i));
      repeat (4) @(negedge clk);
      results();
   end
endmodule

//--- common/nvac_pkg.sv
// Behaviour
// - Keep a 64 by 8 nonvolatile array, reached one byte at a time.
// - Array is not memory mapped; reach it via address, data, control.
// - Address and data registers are plain bank 0 special registers; the code decodes them in both banks.
// - Address register holds six bits; bits 7 and 6 read zero.
// - Store enable bit 3 gates every array write.
// - Store start bit 2 launches a write; hardware clears it at end.
// - Store start does nothing unless store enable was already set.
// - Fetch enable bit 1 gates every array read.
// - Read start bit 0 launches a read; hardware clears it at end.
// - Read start does nothing unless fetch enable was already set.
// - Read byte lands in data register and stays until next operation.
// - Write end sets the done flag; software clears it.
package nvac_pkg;

   // Array geometry
   localparam int ARRAY_DEPTH = 64;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;

   // Register locations; control sits in bank 1 only
   localparam logic [6:0] NVA_OFS = 7'h1E;
   localparam logic [6:0] NVD_OFS = 7'h1F;
   localparam logic [6:0] CTL_OFS = 7'h40;
   localparam logic CTL_BANK = 1'h1;

   // Control field positions
   localparam int RD_BIT = 0;
   localparam int FEN_BIT = 1;
   localparam int WR_BIT = 2;
   localparam int SEN_BIT = 3;

   // Values after reset
   localparam logic [7:0] RST_VAL = 8'h00;

   // Timer tick period and write length in ticks
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] TICK_LAST = 5'(TICK_CYC - 1);
   localparam int WR_TICKS_DEF = 4;

   // Read cycle length in clock cycles
   localparam int READ_CYC = 2;
   localparam logic [1:0] READ_LAST = 2'(READ_CYC - 1);

   typedef enum logic [1:0]
   {
      NVAC_IDLE = 2'b00,
      NVAC_READ = 2'b01,
      NVAC_WRITE = 2'b10
   } nvac_phase_type;

   typedef struct packed {
      logic [ARRAY_DEPTH-1:0][DATA_W-1:0] mem;
      nvac_phase_type phase;
      logic sen;
      logic wr;
      logic fen;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [ADDR_W-1:0] opAddr;
      logic [DATA_W-1:0] opData;
      logic [4:0] pre;
      logic [7:0] ticks;
      logic [1:0] rdCnt;
      logic done;
      logic [DATA_W-1:0] rdata;
   } nvac_state_type;

endpackage

//--- core/nvac_ctrl.sv
`timescale 1ns/1ps
module nvac_ctrl
#(
   parameter int WR_TICKS = nvac_pkg::WR_TICKS_DEF
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Special register access from the core
   input wire logic sfrBank,
   input wire logic [6:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   // Write done flag, cleared by software
   input wire logic doneClr,
   output logic doneFlag
);

   localparam logic [7:0] TICK_END = 8'(WR_TICKS - 1);

   nvac_pkg::nvac_state_type st_r;
   nvac_pkg::nvac_state_type st_nxt;
   logic hitNva;
   logic hitNvd;
   logic hitCtl;
   logic idle;
   logic startWr;
   logic startRd;
   logic tick;

   // Address decode; the control word answers only in bank 1
   always_comb
   begin
      hitNva = sfrWr && (sfrAddr == nvac_pkg::NVA_OFS);
      hitNvd = sfrWr && (sfrAddr == nvac_pkg::NVD_OFS);
      hitCtl = sfrWr && (sfrBank == nvac_pkg::CTL_BANK)
               && (sfrAddr == nvac_pkg::CTL_OFS);
      idle = (st_r.phase == nvac_pkg::NVAC_IDLE);
      tick = (st_r.pre == nvac_pkg::TICK_LAST);
   end

   // Start qualification against the enables held before this write
   always_comb
   begin
      startWr = hitCtl && sfrWdata[nvac_pkg::WR_BIT] && st_r.sen && idle;
      startRd = hitCtl && sfrWdata[nvac_pkg::RD_BIT] && st_r.fen && idle
                && !startWr;
   end

   // Next state of the whole block
   always_comb
   begin
      st_nxt = st_r;

      if (hitNva)
      begin
         st_nxt.addr = sfrWdata[nvac_pkg::ADDR_W-1:0];
      end
      if (hitNvd)
      begin
         st_nxt.data = sfrWdata;
      end

      if (hitCtl)
      begin
         st_nxt.sen = sfrWdata[nvac_pkg::SEN_BIT];
         st_nxt.fen = sfrWdata[nvac_pkg::FEN_BIT];
      end

      // Start bits are owned by hardware once a cycle runs
      case (st_r.phase)
         nvac_pkg::NVAC_IDLE:
         begin
            st_nxt.pre = 5'h00;
            st_nxt.ticks = 8'h00;
            st_nxt.rdCnt = 2'h0;
            if (startWr)
            begin
               st_nxt.wr = 1'b1;
               st_nxt.phase = nvac_pkg::NVAC_WRITE;
               // Latch operands so software edits cannot tear the store
               st_nxt.opAddr = st_r.addr;
               st_nxt.opData = hitNvd ? sfrWdata : st_r.data;
            end
            else if (startRd)
            begin
               st_nxt.rd = 1'b1;
               st_nxt.phase = nvac_pkg::NVAC_READ;
               st_nxt.opAddr = st_r.addr;
            end
         end
         nvac_pkg::NVAC_READ:
         begin
            st_nxt.rdCnt = st_r.rdCnt + 2'h1;
            if (st_r.rdCnt == nvac_pkg::READ_LAST)
            begin
               st_nxt.rd = 1'b0;
               st_nxt.phase = nvac_pkg::NVAC_IDLE;
               st_nxt.data = st_r.mem[st_r.opAddr];
            end
         end
         nvac_pkg::NVAC_WRITE:
         begin
            st_nxt.pre = tick ? 5'h00 : st_r.pre + 5'h01;
            if (tick)
            begin
               st_nxt.ticks = st_r.ticks + 8'h01;
            end
            if (tick && (st_r.ticks == TICK_END))
            begin
               st_nxt.wr = 1'b0;
               st_nxt.phase = nvac_pkg::NVAC_IDLE;
               st_nxt.mem[st_r.opAddr] = st_r.opData;
            end
         end
         default:
         begin
            st_nxt.phase = nvac_pkg::NVAC_IDLE;
            st_nxt.wr = 1'b0;
            st_nxt.rd = 1'b0;
         end
      endcase

      if (doneClr)
      begin
         st_nxt.done = 1'b0;
      end
      if (st_r.wr && !st_nxt.wr)
      begin
         st_nxt.done = 1'b1;
      end

      // Registered read port; unmapped locations answer zero
      st_nxt.rdata = nvac_pkg::RST_VAL;
      if (sfrAddr == nvac_pkg::NVA_OFS)
      begin
         st_nxt.rdata = {2'b00, st_r.addr};
      end
      else if (sfrAddr == nvac_pkg::NVD_OFS)
      begin
         st_nxt.rdata = st_r.data;
      end
      else if (sfrBank == nvac_pkg::CTL_BANK
               && sfrAddr == nvac_pkg::CTL_OFS)
      begin
         st_nxt.rdata = {4'h0, st_r.sen, st_r.wr, st_r.fen, st_r.rd};
      end

      // reset zero; the array is nonvolatile and keeps its bytes
      if (sys_rst)
      begin
         st_nxt = '0;
         st_nxt.mem = st_r.mem;
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      st_r <= st_nxt;
   end

   // Outputs straight from flops
   assign sfrRdata = st_r.rdata;
   assign doneFlag = st_r.done;

   // Checks and coverage
   localparam int WR_LEN = WR_TICKS * nvac_pkg::TICK_CYC;
   localparam int WR_HOLD = WR_LEN - 1;
   localparam int RD_LEN = nvac_pkg::READ_CYC;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_addr_upper: assert property (
      $past(sfrAddr == nvac_pkg::NVA_OFS) |-> sfrRdata[7:6] == 2'b00)
      else $error("address register upper bits not zero");

   chk_wr_refused: assert property (
      hitCtl && sfrWdata[nvac_pkg::WR_BIT] && !st_r.sen && idle
      |=> !st_r.wr && st_r.phase != nvac_pkg::NVAC_WRITE)
      else $error("store start took effect without store enable");

   chk_rd_refused: assert property (
      hitCtl && sfrWdata[nvac_pkg::RD_BIT] && !st_r.fen && idle
      |=> !st_r.rd && st_r.phase != nvac_pkg::NVAC_READ)
      else $error("read start took effect without fetch enable");

   chk_wr_length: assert property (
      $rose(st_r.wr) |-> ##[WR_HOLD:WR_HOLD] st_r.wr ##1 !st_r.wr)
      else $error("write cycle length wrong");

   chk_rd_length: assert property (
      $rose(st_r.rd) |-> ##[RD_LEN:RD_LEN] !st_r.rd)
      else $error("read cycle length wrong");

   chk_done_set: assert property (
      $fell(st_r.wr) |-> doneFlag)
      else $error("done flag not set at write end");

   chk_rd_result: assert property (
      $fell(st_r.rd) |-> st_r.data == st_r.mem[st_r.opAddr])
      else $error("read byte not in data register");

   chk_byte_store: assert property (
      $fell(st_r.wr) |-> st_r.mem[st_r.opAddr] == st_r.opData)
      else $error("written byte not stored");

   chk_busy_ignore: assert property (
      st_r.phase == nvac_pkg::NVAC_WRITE && hitCtl
      && sfrWdata[nvac_pkg::RD_BIT] |=> !st_r.rd)
      else $error("read started during write cycle");

   chk_reset_zero: assert property (
      $past(sys_rst) |-> st_r.addr == 6'h00 && st_r.data == 8'h00
      && !st_r.sen && !st_r.wr && !st_r.fen && !st_r.rd)
      else $error("registers not zero after reset");

   chk_direct_data: assert property (
      hitNvd && idle && !startWr |=> st_r.data == $past(sfrWdata))
      else $error("data register write lost");

   chk_wr_gated: assert property (
      !st_r.sen |=> !$rose(st_r.wr))
      else $error("write cycle began without store enable");

   chk_rd_gated: assert property (
      !st_r.fen |=> !$rose(st_r.rd))
      else $error("read cycle began without fetch enable");

   chk_ctl_bank: assert property (
      sfrWr && sfrAddr == nvac_pkg::CTL_OFS
      && sfrBank != nvac_pkg::CTL_BANK
      |=> $stable(st_r.sen) && $stable(st_r.fen))
      else $error("control register written from bank 0");

   chk_wr_busy: assert property (
      st_r.phase == nvac_pkg::NVAC_READ && hitCtl
      && sfrWdata[nvac_pkg::WR_BIT] |=> !$rose(st_r.wr))
      else $error("write started during read cycle");

   // one cycle only; a second start would tear the operand latch
   chk_one_cycle: assert property (
      !(st_r.wr && st_r.rd))
      else $error("read and write cycles overlap");

   chk_done_hold: assert property (
      doneFlag && !doneClr |=> doneFlag)
      else $error("done flag dropped without clear");

   chk_data_hold: assert property (
      idle && !hitNvd |=> $stable(st_r.data))
      else $error("data register changed without an access");

   cov_write_done: cover property (
      $rose(st_r.wr) ##[WR_HOLD:WR_HOLD] st_r.wr ##1 doneFlag);

   cov_read_done: cover property ($fell(st_r.rd));

   cov_wr_refused: cover property (
      hitCtl && sfrWdata[nvac_pkg::WR_BIT] && !st_r.sen && idle);

   cov_busy_start: cover property (
      !idle && hitCtl && sfrWdata[nvac_pkg::RD_BIT]);

   cov_done_race: cover property ($fell(st_r.wr) && $past(doneClr));

endmodule
